// >>> rtl/abiu_pkg.sv
// constants for the array bus interface unit
package abiu_pkg;
    localparam int SB_DW = 64;
    localparam int LINE_W = 256;
    localparam int ADDR_W = 32;
    localparam int LINE_LO = 5;
    localparam int WSEL_LO = 3;
    localparam int MID_W = 2;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STAT = 8'h04;
    localparam logic [7:0] REG_PFCMD = 8'h08;
    localparam int C_PF_EN = 0;
    localparam int C_AUTO = 1;
    localparam int C_INSTR = 2;
    localparam int C_DATA = 3;
    localparam int C_MRESTR = 4;
    localparam int C_MID_LO = 8;
    localparam int C_INVAL = 16;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] CTRL_MASK = 32'h0000_031F;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_DEM = 2'b01,
        ST_FWD = 2'b11,
        ST_PREF = 2'b10
    } abiu_state_e;
endpackage

// >>> rtl/abiu_top.sv
// array bus interface unit with two line prefetch buffers
//
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module abiu_top #(
    parameter int AW = abiu_pkg::ADDR_W,
    parameter int DW = abiu_pkg::SB_DW,
    parameter int LW = abiu_pkg::LINE_W,
    parameter int MW = abiu_pkg::MID_W
) (
    input wire logic CLK_I,
    input wire logic SYS_RST_I,
    input wire logic SB_REQ_I,
    input wire logic [AW-1:0] SB_ADDR_I,
    input wire logic [MW-1:0] SB_MASTER_I,
    input wire logic SB_INSTR_I,
    output logic SB_READY_O,
    output logic SB_ACK_O,
    output logic [DW-1:0] SB_RDATA_O,
    output logic AR_REQ_O,
    output logic [AW-1:0] AR_ADDR_O,
    input wire logic AR_VALID_I,
    input wire logic [LW-1:0] AR_DATA_I,
    input wire logic ARR_CHG_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O
);
    localparam int TW = AW - abiu_pkg::LINE_LO;
    localparam int WSW = abiu_pkg::LINE_LO - abiu_pkg::WSEL_LO;

    abiu_pkg::abiu_state_e state;
    logic [TW-1:0] tag_q [2];
    logic [LW-1:0] line_q [2];
    logic [1:0] bvalid;
    logic lru;
    logic discard;
    logic [31:0] ctrl;
    logic pend;
    logic [TW-1:0] pf_tag;
    logic [WSW-1:0] dem_wsel;
    logic [DW-1:0] hold;

    logic [TW-1:0] req_tag;
    logic [WSW-1:0] req_wsel;
    logic accept;
    logic hit0;
    logic hit1;
    logic hit;
    logic hit_idx;
    logic victim;
    logic fill;
    logic in_flight;
    logic apb_wr;
    logic inval;
    logic trig;
    logic nxt_present;
    logic [TW-1:0] nxt_tag;
    logic man_pf;
    logic issue_pf;

    function automatic logic [DW-1:0] pick(input logic [LW-1:0] ln,
                                           input logic [WSW-1:0] w);
        pick = ln[w*DW +: DW];
    endfunction

    assign req_tag = SB_ADDR_I[AW-1:abiu_pkg::LINE_LO];
    assign req_wsel = SB_ADDR_I[abiu_pkg::LINE_LO-1:abiu_pkg::WSEL_LO];
    assign SB_READY_O = (state == abiu_pkg::ST_IDLE);
    assign accept = SB_REQ_I && SB_READY_O;
    assign hit0 = bvalid[0] && (tag_q[0] == req_tag);
    assign hit1 = bvalid[1] && (tag_q[1] == req_tag);
    assign hit = hit0 || hit1;
    assign hit_idx = hit1 && !hit0;
    // empty buffer first, else least recently used
    assign victim = !bvalid[0] ? 1'b0 : (!bvalid[1] ? 1'b1 : lru);
    assign in_flight = (state == abiu_pkg::ST_DEM) ||
                       (state == abiu_pkg::ST_PREF);
    assign fill = AR_VALID_I && in_flight;
    assign apb_wr = PSEL_I && PENABLE_I && PWRITE_I;
    assign inval = ARR_CHG_I || (apb_wr && (PADDR_I == abiu_pkg::REG_CTRL)
                                 && PWDATA_I[abiu_pkg::C_INVAL]);

    // prefetch trigger from the access just taken
    assign nxt_tag = req_tag + TW'(1);
    assign nxt_present = (bvalid[0] && (tag_q[0] == nxt_tag)) ||
                         (bvalid[1] && (tag_q[1] == nxt_tag));
    assign trig = accept && ctrl[abiu_pkg::C_PF_EN] &&
                  ctrl[abiu_pkg::C_AUTO] &&
                  (!ctrl[abiu_pkg::C_MRESTR] ||
                   (SB_MASTER_I == ctrl[abiu_pkg::C_MID_LO +: MW])) &&
                  (SB_INSTR_I ? ctrl[abiu_pkg::C_INSTR] :
                   ctrl[abiu_pkg::C_DATA]) &&
                  !nxt_present;
    assign man_pf = apb_wr && (PADDR_I == abiu_pkg::REG_PFCMD) &&
                    ctrl[abiu_pkg::C_PF_EN];
    assign issue_pf = (state == abiu_pkg::ST_IDLE) && !accept && pend;

    // control register
    always_ff @(posedge CLK_I)
    begin
        if (SYS_RST_I)
        begin
            ctrl <= abiu_pkg::CTRL_RST;
        end
        else if (apb_wr && (PADDR_I == abiu_pkg::REG_CTRL))
        begin
            ctrl <= PWDATA_I & abiu_pkg::CTRL_MASK;
        end
    end

    // pending prefetch; a new trigger wins over the clear at issue
    always_ff @(posedge CLK_I)
    begin
        if (SYS_RST_I)
        begin
            pend <= 1'b0;
            pf_tag <= '0;
        end
        else if (trig)
        begin
            pend <= 1'b1;
            pf_tag <= nxt_tag;
        end
        else if (man_pf)
        begin
            pend <= 1'b1;
            pf_tag <= PWDATA_I[AW-1:abiu_pkg::LINE_LO];
        end
        else if (issue_pf || inval)
        begin
            pend <= 1'b0;
        end
    end

    // sequencer
    always_ff @(posedge CLK_I)
    begin
        if (SYS_RST_I)
        begin
            state <= abiu_pkg::ST_IDLE;
            AR_REQ_O <= 1'b0;
            AR_ADDR_O <= '0;
            dem_wsel <= '0;
        end
        else
        begin
            AR_REQ_O <= 1'b0;
            case (state)
                abiu_pkg::ST_IDLE:
                begin
                    if (accept && !hit)
                    begin
                        state <= abiu_pkg::ST_DEM;
                        AR_REQ_O <= 1'b1;
                        AR_ADDR_O <= {req_tag, {abiu_pkg::LINE_LO{1'b0}}};
                        dem_wsel <= req_wsel;
                    end
                    else if (issue_pf)
                    begin
                        state <= abiu_pkg::ST_PREF;
                        AR_REQ_O <= 1'b1;
                        AR_ADDR_O <= {pf_tag, {abiu_pkg::LINE_LO{1'b0}}};
                    end
                end
                abiu_pkg::ST_DEM:
                begin
                    if (AR_VALID_I)
                    begin
                        state <= abiu_pkg::ST_FWD;
                    end
                end
                abiu_pkg::ST_FWD:
                begin
                    state <= abiu_pkg::ST_IDLE;
                end
                abiu_pkg::ST_PREF:
                begin
                    if (AR_VALID_I)
                    begin
                        state <= abiu_pkg::ST_IDLE;
                    end
                end
                default:
                begin
                    state <= abiu_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // read answer to the system bus
    always_ff @(posedge CLK_I)
    begin
        if (SYS_RST_I)
        begin
            SB_ACK_O <= 1'b0;
            SB_RDATA_O <= '0;
            hold <= '0;
        end
        else
        begin
            SB_ACK_O <= 1'b0;
            if (accept && hit)
            begin
                SB_ACK_O <= 1'b1;
                SB_RDATA_O <= pick(line_q[hit_idx], req_wsel);
            end
            else if (state == abiu_pkg::ST_DEM && AR_VALID_I)
            begin
                hold <= pick(AR_DATA_I, dem_wsel);
            end
            else if (state == abiu_pkg::ST_FWD)
            begin
                SB_ACK_O <= 1'b1;
                SB_RDATA_O <= hold;
            end
        end
    end

    // fetch in flight at invalidation is dropped when it lands
    always_ff @(posedge CLK_I)
    begin
        if (SYS_RST_I)
        begin
            discard <= 1'b0;
        end
        else if (inval && in_flight && !AR_VALID_I)
        begin
            discard <= 1'b1;
        end
        else if (fill)
        begin
            discard <= 1'b0;
        end
    end

    // prefetch buffers, replacement order and invalidation
    always_ff @(posedge CLK_I)
    begin
        if (SYS_RST_I)
        begin
            bvalid <= 2'b00;
            lru <= 1'b0;
            tag_q[0] <= '0;
            tag_q[1] <= '0;
            line_q[0] <= '0;
            line_q[1] <= '0;
        end
        else if (inval)
        begin
            bvalid <= 2'b00;
        end
        else
        begin
            if (fill)
            begin
                if (!discard)
                begin
                    tag_q[victim] <= AR_ADDR_O[AW-1:abiu_pkg::LINE_LO];
                    line_q[victim] <= AR_DATA_I;
                    bvalid[victim] <= 1'b1;
                    lru <= ~victim;
                end
            end
            else if (accept && hit)
            begin
                lru <= ~hit_idx;
            end
        end
    end

    // register read port
    assign PREADY_O = 1'b1;
    always_comb
    begin
        PRDATA_O = 32'h0000_0000;
        PSLVERR_O = 1'b0;
        case (PADDR_I)
            abiu_pkg::REG_CTRL: PRDATA_O = ctrl;
            abiu_pkg::REG_STAT: PRDATA_O = 32'({state, pend, lru, bvalid});
            abiu_pkg::REG_PFCMD:
                PRDATA_O = {pf_tag, {abiu_pkg::LINE_LO{1'b0}}};
            default: PSLVERR_O = PSEL_I && PENABLE_I;
        endcase
    end
endmodule
`default_nettype wire

// >>> tb/abiu_top_asserts.sv
// port assertions for the array bus interface unit
`timescale 1ns/10ps
`default_nettype none
module abiu_top_asserts (
    input wire logic CLK_I,
    input wire logic SYS_RST_I,
    input wire logic SB_REQ_I,
    input wire logic SB_READY_O,
    input wire logic SB_ACK_O,
    input wire logic [63:0] SB_RDATA_O,
    input wire logic AR_REQ_O,
    input wire logic [31:0] AR_ADDR_O,
    input wire logic AR_VALID_I
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (SYS_RST_I);
    sequence s_take; SB_REQ_I && SB_READY_O; endsequence
    sequence s_miss; s_take ##1 AR_REQ_O ##1 AR_VALID_I; endsequence
    a_line_align: assert property (AR_REQ_O |-> AR_ADDR_O[4:0] == 5'h00)
        else $error("line address unaligned");
    a_req_pulse: assert property (AR_REQ_O |=> !AR_REQ_O)
        else $error("array request too long");
    a_busy_fetch: assert property (AR_REQ_O |-> !SB_READY_O [*2])
        else $error("ready during fetch");
    a_take_answer: assert property (s_take |=> SB_ACK_O || AR_REQ_O)
        else $error("request not answered");
    a_wait_three: assert property (s_miss |-> ##2 SB_ACK_O)
        else $error("miss ack late");
    a_fill_ack: assert property (SB_ACK_O && !$past(SB_READY_O)
        |-> $past(AR_VALID_I, 2))
        else $error("ack without fill");
    a_rdata_hold: assert property (!SB_ACK_O |-> $stable(SB_RDATA_O))
        else $error("read data moved");
    a_ack_ready: assert property (SB_ACK_O |-> SB_READY_O)
        else $error("not ready at ack");
endmodule
`default_nettype wire

// >>> tb/abiu_arr_model.sv
// array controller model answering line reads after a delay
`timescale 1ns/10ps
`default_nettype none
module abiu_arr_model (
    input wire logic clk_i,
    input wire logic req_i,
    input wire logic [31:0] addr_i,
    input wire logic [3:0] lat_i,
    output logic valid_o,
    output logic [255:0] data_o
);
    logic [31:0] a = 32'h0;
    logic [31:0] la;
    int n = 0;
    int ln;
    function automatic logic [63:0] wd(input logic [31:0] v);
        return {v[31:3], 3'h5, ~v};
    endfunction
    initial valid_o = 1'b0;
    initial data_o = '0;
    // a new request restarts the countdown in its own cycle
    always_comb
    begin
        la = req_i ? addr_i : a;
        ln = req_i ? int'(lat_i) : n;
    end
    always @(posedge clk_i)
    begin
        valid_o <= 1'b0;
        data_o <= ~data_o;
        a <= la;
        n <= (ln != 0) ? ln - 1 : 0;
        if (ln == 1)
        begin
            valid_o <= 1'b1;
            for (int w = 0; w < 4; w++)
                data_o[w*64 +: 64] <= wd({la[31:5], 2'(w), 3'h0});
        end
    end
endmodule
`default_nettype wire

// >>> tb/tb_abiu_top.sv
// testbench for the array bus interface unit
`timescale 1ns/10ps
`default_nettype none
module tb_abiu_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic req = 1'b0;
    logic ins = 1'b0;
    logic chg = 1'b0;
    logic ps = 1'b0;
    logic pe = 1'b0;
    logic pw = 1'b0;
    logic [1:0] mid = 2'h0;
    logic [7:0] pa = 8'h00;
    logic [31:0] pd = 32'h0;
    logic [31:0] ad = 32'h0;
    logic [3:0] lat = 4'h1;
    logic rdy, ack, areq, aval, prdy, perr, e;
    logic [63:0] rdat;
    logic [31:0] aadr, prd, r, x;
    logic [255:0] adat;
    logic [63:0] qd[$];
    int ql[$];
    int cyc = 0;
    int t0 = 0;
    int miscompares = 0;
    int tests_run = 0;
    logic [23:0] cfg[10] = '{24'h00000F, 24'h31000B, 24'h00000B, 24'h300007,
        24'h010007, 24'h30211F, 24'h00111F, 24'h300000, 24'h01300F,
        24'h300001};
    abiu_top dut (.CLK_I(clk), .SYS_RST_I(rst), .SB_REQ_I(req),
        .SB_ADDR_I(ad), .SB_MASTER_I(mid), .SB_INSTR_I(ins),
        .SB_READY_O(rdy), .SB_ACK_O(ack), .SB_RDATA_O(rdat),
        .AR_REQ_O(areq), .AR_ADDR_O(aadr), .AR_VALID_I(aval),
        .AR_DATA_I(adat), .ARR_CHG_I(chg), .PSEL_I(ps), .PENABLE_I(pe),
        .PWRITE_I(pw), .PADDR_I(pa), .PWDATA_I(pd), .PRDATA_O(prd),
        .PREADY_O(prdy), .PSLVERR_O(perr));
    abiu_arr_model arr (.clk_i(clk), .req_i(areq), .addr_i(aadr),
        .lat_i(lat), .valid_o(aval), .data_o(adat));
    always #20 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    task automatic chk(input logic [63:0] s, input logic [63:0] v);
        tests_run++;
        if (s !== v)
        begin
            miscompares++;
            $display("MISMATCH %0t seen %h exp %h", $time, s, v);
        end
    endtask
    task end_of_test;
        $display("miscompares %0d tests_run %0d", miscompares, tests_run);
        if (miscompares == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic rd(input logic [31:0] a, input logic [23:0] c, int l);
        qd.push_back(arr.wd(a));
        ql.push_back(l);
        req <= 1'b1;
        ad <= a;
        mid <= c[13:12];
        ins <= c[16];
        do @(posedge clk); while (rdy !== 1'b1);
    endtask
    task automatic idle(input int n);
        req <= 1'b0;
        repeat (n) @(posedge clk);
    endtask
    task automatic apb(input logic w, input logic [7:0] a, logic [31:0] d);
        ps <= 1'b1;
        pw <= w;
        pa <= a;
        pd <= d;
        @(posedge clk);
        pe <= 1'b1;
        do @(posedge clk); while (prdy !== 1'b1);
        r = prd;
        e = perr;
        ps <= 1'b0;
        pe <= 1'b0;
        @(posedge clk);
    endtask
    always @(negedge clk)
    begin
        if (ack === 1'b1)
        begin
            chk(rdat, qd.pop_front());
            chk(64'(cyc - t0), 64'(ql.pop_front()));
        end
        if (req === 1'b1 && rdy === 1'b1)
            t0 = cyc + 1;
    end
    initial
    begin
        repeat (5000) @(posedge clk);
        miscompares++;
        end_of_test;
    end
    initial
    begin
        void'($urandom(69306));
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        apb(1'b0, 8'h00, 32'h0);
        chk(64'(r), 64'h0);
        apb(1'b0, 8'h0C, 32'h0);
        chk(64'({e, r}), 64'h1_0000_0000);
        apb(1'b0, 8'h04, 32'h0);
        chk(64'(r), 64'h0);
        foreach (cfg[i])
        begin
            apb(1'b1, 8'h00, 32'h0001_0000 | 32'(cfg[i][11:0]));
            apb(1'b0, 8'h00, 32'h0);
            chk(64'(r), 64'(cfg[i][11:0]));
            x = $urandom & 32'h00FF_FF00;
            rd(x, cfg[i], 3);
            rd(x + 8, cfg[i], 0);
            idle(8);
            rd(x + 32 + ($urandom & 32'h18), cfg[i], cfg[i][23:20]);
            idle(8);
        end
        idle(8);
        chg <= 1'b1;
        @(posedge clk);
        chg <= 1'b0;
        rd(x + 32, 24'h0, 3);
        idle(8);
        lat <= 4'h4;
        rd(x ^ 32'h0100_0000, 24'h0, 6);
        idle(8);
        apb(1'b1, 8'h08, x ^ 32'h0200_0000);
        apb(1'b0, 8'h08, 32'h0);
        chk(64'(r), 64'(x ^ 32'h0200_0000));
        rd((x ^ 32'h0200_0000) + 16, 24'h0, 0);
        rd((x ^ 32'h0100_0000) + 8, 24'h0, 0);
        rd(x + 32, 24'h0, 6);
        idle(8);
        apb(1'b0, 8'h04, 32'h0);
        chk(64'(r), 64'h7);
        end_of_test;
    end
endmodule
bind abiu_top abiu_top_asserts chk_u (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I),
    .SB_REQ_I(SB_REQ_I), .SB_READY_O(SB_READY_O), .SB_ACK_O(SB_ACK_O),
    .SB_RDATA_O(SB_RDATA_O), .AR_REQ_O(AR_REQ_O), .AR_ADDR_O(AR_ADDR_O),
    .AR_VALID_I(AR_VALID_I));
`default_nettype wire
